/* File: src/sdr_pkg.sv */
// Shared constants and address decoders for the shadowed register map.
package sdr_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int          ADDR_W     = 13;
  localparam int          FRAME_BITS = 24;
  localparam int          RNW_POS    = 15;
  localparam logic [4:0]  INSTR_LAST = 5'h0F;
  localparam logic [4:0]  DATA_FIRST = 5'h10;
  localparam logic [4:0]  FRAME_LAST = 5'h17;
  localparam logic [1:0]  W_SINGLE   = 2'h0;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [12:0] PCFG_A    = 13'h000;
  localparam logic [12:0] CHIP_ID_A = 13'h001;
  localparam logic [12:0] GRADE_A   = 13'h002;
  localparam logic [12:0] CIDX_A    = 13'h005;
  localparam logic [12:0] XFER_A    = 13'h0FF;
  localparam logic [12:0] FN_LO     = 13'h008;
  localparam logic [12:0] CLK_A     = 13'h009;
  localparam logic [12:0] FMT_A     = 13'h014;
  localparam logic [12:0] SHD_HI    = 13'h020;
  localparam logic [12:0] FN_HI     = 13'h025;
  localparam logic [12:0] FEAT_LO   = 13'h03A;
  localparam logic [12:0] FEAT_HI   = 13'h059;

  // ----------------------------------------
  // Storage indices, fields and defaults
  // ----------------------------------------
  localparam int          N_ENT     = 62;
  localparam logic [5:0]  FEAT_BASE = 6'h1E;
  localparam logic [5:0]  IDX_CLK   = 6'h01;
  localparam logic [5:0]  IDX_FMT   = 6'h0C;
  localparam logic [5:0]  IDX_SHD   = 6'h18;
  localparam logic [7:0]  PCFG_RST  = 8'h18;
  localparam logic [7:0]  PCFG_RW   = 8'h42;
  localparam logic [7:0]  SOFT_MASK = 8'h24;
  localparam logic [7:0]  CIDX_RST  = 8'h03;
  localparam logic [7:0]  CIDX_MASK = 8'h03;
  localparam logic [7:0]  FMT_RST   = 8'h05;
  localparam logic [7:0]  CLK_RST   = 8'h01;
  localparam logic [7:0]  XFER_CMD  = 8'h01;
  localparam int          CH_A_BIT  = 0;
  localparam int          CH_B_BIT  = 1;
  localparam int          DCC_BIT   = 0;

  // ----------------------------------------
  // Host command registers
  // ----------------------------------------
  localparam logic [2:0]  H_ALO_R   = 3'h0;
  localparam logic [2:0]  H_AHI_R   = 3'h1;
  localparam logic [2:0]  H_WD_R    = 3'h2;
  localparam logic [2:0]  H_CTRL_R  = 3'h3;
  localparam logic [2:0]  H_RD_R    = 3'h4;
  localparam int          H_GO_BIT  = 0;
  localparam int          H_RNW_BIT = 1;
  localparam int          H_ERR_BIT = 1;

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  function automatic logic sdr_in_map(input logic [12:0] a);
    return (a >= FN_LO && a <= FN_HI) || (a >= FEAT_LO && a <= FEAT_HI);
  endfunction

  function automatic logic sdr_is_shadowed(input logic [12:0] a);
    return (a >= FN_LO && a <= SHD_HI) || (a >= FEAT_LO && a <= FEAT_HI);
  endfunction

  function automatic logic sdr_idx_shadowed(input logic [5:0] i);
    return i <= IDX_SHD || i >= FEAT_BASE;
  endfunction

  function automatic logic sdr_is_local(input logic [12:0] a);
    return a >= FN_LO && a <= FN_HI && a != CLK_A;
  endfunction

  function automatic logic sdr_supported(input logic [12:0] a);
    return a <= GRADE_A || a == CIDX_A || a == XFER_A || sdr_in_map(a);
  endfunction

  function automatic logic [5:0] sdr_idx(input logic [12:0] a);
    if (a <= FN_HI) begin
      return 6'(a - FN_LO);
    end
    return 6'(a - FEAT_LO) + FEAT_BASE;
  endfunction

  function automatic logic [7:0] sdr_dflt(input logic [5:0] i);
    if (i == IDX_CLK) begin
      return CLK_RST;
    end
    if (i == IDX_FMT) begin
      return FMT_RST;
    end
    return 8'h00;
  endfunction

endpackage

/* File: src/sdr_spi_if.sv */
// Three-wire serial link joining the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
interface sdr_spi_if;
  logic sclk;
  logic csb_n;
  logic sdio_h_o;
  logic sdio_h_oe;
  logic sdio_d_o;
  logic sdio_d_oe;
  logic sdio;

  // The shared data wire idles high as with a pull-up.
  assign sdio = sdio_d_oe ? sdio_d_o : (sdio_h_oe ? sdio_h_o : 1'b1);

  modport host (
    output sclk,
    output csb_n,
    output sdio_h_o,
    output sdio_h_oe,
    input  sdio
  );

  modport dev (
    input  sclk,
    input  csb_n,
    input  sdio,
    output sdio_d_o,
    output sdio_d_oe
  );
endinterface
`default_nettype wire

/* File: src/sdr_sync.sv */
// Two-stage synchroniser for levels and toggles.
`timescale 1ns/1ps
`default_nettype none
module sdr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: src/sdr_dev.sv */
// Device end: serial slave and shadowed dual-channel register bank.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sdr_dev
  import sdr_pkg::*;
#(
  // Arbitrary neutral identity value.
  parameter logic [7:0] CHIP_ID = 8'hA5,
  parameter logic [7:0] GRADE   = 8'h20
) (
  // Sample clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Serial link
  sdr_spi_if.dev          link,
  // Applied settings
  output logic      [7:0] fmt_a,
  output logic      [7:0] fmt_b,
  output logic            duty_cycle_corrector_en,
  output logic      [1:0] chan_sel,
  output logic            xfer_pulse
);

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic [4:0]  cnt_q;
  logic [14:0] sh_q;
  logic [15:0] instr;
  logic        rnw_q;
  logic [12:0] l_addr_q;
  logic [12:0] wa_q;
  logic [7:0]  wd_q;
  logic [12:0] ra_q;
  logic        wr_tgl_q;
  logic        rd_tgl_q;
  logic [7:0]  rd_q;

  assign instr = {sh_q, link.sdio};

  // Frame state ends with the frame: chip select high clears it at once,
  // so no link edge is needed after the last bit.
  always_ff @(posedge link.sclk or posedge link.csb_n) begin
    if (link.csb_n) begin
      cnt_q <= 5'h00;
      sh_q  <= 15'h0000;
    end else begin
      sh_q  <= instr[14:0];
      cnt_q <= (cnt_q == FRAME_LAST) ? DATA_FIRST : cnt_q + 5'h01;
    end
  end

  // Streaming frames step to the next lower address after each byte.
  always_ff @(posedge link.sclk or posedge link.csb_n) begin
    if (link.csb_n) begin
      rnw_q    <= 1'b0;
      l_addr_q <= 13'h0000;
    end else if (cnt_q == INSTR_LAST) begin
      rnw_q    <= instr[RNW_POS];
      l_addr_q <= instr[ADDR_W-1:0];
    end else if (cnt_q == FRAME_LAST) begin
      l_addr_q <= l_addr_q - 13'h0001;
    end
  end

  // Completed write bytes are held here until the next one, far longer
  // than the core side needs to see the toggle and take them.
  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      wa_q     <= 13'h0000;
      wd_q     <= 8'h00;
      wr_tgl_q <= 1'b0;
    end else if (cnt_q == FRAME_LAST && !rnw_q) begin
      wa_q     <= l_addr_q;
      wd_q     <= instr[7:0];
      wr_tgl_q <= !wr_tgl_q;
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      ra_q     <= 13'h0000;
      rd_tgl_q <= 1'b0;
    end else if (cnt_q == INSTR_LAST && instr[RNW_POS]) begin
      ra_q     <= instr[ADDR_W-1:0];
      rd_tgl_q <= !rd_tgl_q;
    end else if (cnt_q == FRAME_LAST && rnw_q) begin
      ra_q     <= l_addr_q - 13'h0001;
      rd_tgl_q <= !rd_tgl_q;
    end
  end

  // Read data is a settled core register; the host leaves a gap after
  // the instruction so that the lookup is done before the first bit.
  logic        doe_q;

  // The turn-around waits for the falling edge, when the host lets go,
  // so that the two ends never drive the wire together.
  always_ff @(negedge link.sclk or posedge link.csb_n) begin
    if (link.csb_n) begin
      doe_q <= 1'b0;
    end else begin
      doe_q <= rnw_q && cnt_q[4];
    end
  end

  assign link.sdio_d_oe = doe_q;
  assign link.sdio_d_o  = rd_q[~cnt_q[2:0]];

  // ----------------------------------------
  // Crossing into the sample domain
  // ----------------------------------------
  logic [1:0] tg_s;
  logic [1:0] tg_q;
  logic       wr_ev;
  logic       rd_ev;

  sdr_sync #(
    .W(2)
  ) u_sync (
    .clk  (core_clk),
    .rst_n(rst_n),
    .d    ({rd_tgl_q, wr_tgl_q}),
    .q    (tg_s)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tg_q <= 2'h0;
    end else begin
      tg_q <= tg_s;
    end
  end

  assign wr_ev = tg_s[0] ^ tg_q[0];
  assign rd_ev = tg_s[1] ^ tg_q[1];

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  logic [7:0] shd_a [N_ENT];
  logic [7:0] shd_b [N_ENT];
  logic [7:0] act_a [N_ENT];
  logic [7:0] act_b [N_ENT];
  logic [7:0] pcfg_q;
  logic [7:0] cidx_q;
  logic       xfer_q;
  logic       soft_q;
  logic [5:0] wi;
  logic       wsel_a;
  logic       wsel_b;

  assign wi     = sdr_idx(wa_q);
  assign wsel_a = !sdr_is_local(wa_q) || cidx_q[CH_A_BIT];
  assign wsel_b = sdr_is_local(wa_q) && cidx_q[CH_B_BIT];

  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_q) begin
      for (int i = 0; i < N_ENT; i++) begin
        shd_a[i] <= sdr_dflt(6'(i));
        shd_b[i] <= sdr_dflt(6'(i));
        act_a[i] <= sdr_dflt(6'(i));
        act_b[i] <= sdr_dflt(6'(i));
      end
      pcfg_q <= PCFG_RST & PCFG_RW;
      cidx_q <= CIDX_RST;
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= 1'b0;
      if (xfer_q) begin
        for (int i = 0; i < N_ENT; i++) begin
          if (sdr_idx_shadowed(6'(i))) begin
            act_a[i] <= shd_a[i];
            act_b[i] <= shd_b[i];
          end
        end
      end
      if (wr_ev) begin
        if (wa_q == PCFG_A) begin
          pcfg_q <= wd_q & PCFG_RW;
        end
        if (wa_q == CIDX_A) begin
          cidx_q <= wd_q & CIDX_MASK;
        end
        // A new command in the clearing cycle still fires.
        if (wa_q == XFER_A && wd_q == XFER_CMD) begin
          xfer_q <= 1'b1;
        end
        if (sdr_in_map(wa_q)) begin
          if (wsel_a) begin
            shd_a[wi] <= wd_q;
          end
          if (wsel_b) begin
            shd_b[wi] <= wd_q;
          end
          if (!sdr_is_shadowed(wa_q) && wsel_a) begin
            act_a[wi] <= wd_q;
          end
          if (!sdr_is_shadowed(wa_q) && wsel_b) begin
            act_b[wi] <= wd_q;
          end
        end
      end
    end
  end

  // Soft reset is a one-cycle request, so the bits never read back set.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_ev && wa_q == PCFG_A && |(wd_q & SOFT_MASK);
    end
  end

  // ----------------------------------------
  // Read lookup
  // ----------------------------------------
  logic [7:0] rv;
  logic [5:0] ri;

  always_comb begin
    rv = 8'h00;
    ri = sdr_idx(ra_q);
    if (ra_q == PCFG_A) begin
      rv = pcfg_q | PCFG_RST;
    end else if (ra_q == CHIP_ID_A) begin
      rv = CHIP_ID;
    end else if (ra_q == GRADE_A) begin
      rv = GRADE;
    end else if (ra_q == CIDX_A) begin
      rv = cidx_q;
    end else if (ra_q == XFER_A) begin
      rv = {7'h00, xfer_q};
    end else if (sdr_in_map(ra_q)) begin
      if (sdr_is_local(ra_q) && !cidx_q[CH_A_BIT] && cidx_q[CH_B_BIT]) begin
        rv = shd_b[ri];
      end else begin
        rv = shd_a[ri];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
    end else if (rd_ev) begin
      rd_q <= rv;
    end
  end

  // ----------------------------------------
  // Applied settings
  // ----------------------------------------
  assign fmt_a                   = act_a[IDX_FMT];
  assign fmt_b                   = act_b[IDX_FMT];
  assign duty_cycle_corrector_en = act_a[IDX_CLK][DCC_BIT];
  assign chan_sel                = cidx_q[1:0];
  assign xfer_pulse              = xfer_q;

endmodule
`default_nettype wire

/* File: src/sdr_host.sv */
// Host end: serial master driven through a small command register port.
`timescale 1ns/1ps
`default_nettype none
module sdr_host
  import sdr_pkg::*;
#(
  parameter int SCLK_HALF = 4,
  parameter int RD_GAP    = 16
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Serial link
  sdr_spi_if.host         link,
  // Command port
  input  wire logic [2:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  output logic      [7:0] cmd_rdata
);

  typedef enum {H_IDLE, H_LOW, H_HIGH, H_GAP} sdr_hst_t;

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
  localparam logic [7:0] GAP_LAST  = 8'(RD_GAP - 1);

  sdr_hst_t    st_q;
  logic [12:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic [7:0]  chsel_q;
  logic        err_q;
  logic        rnw_q;
  logic [23:0] fr_q;
  logic [4:0]  bit_q;
  logic [7:0]  div_q;
  logic        sclk_q;
  logic        csb_q;
  logic        sdi_s;
  logic        busy;
  logic        go;
  logic        go_rd;
  logic        go_ok;
  logic        tick;

  sdr_sync #(
    .W(1)
  ) u_sync (
    .clk  (core_clk),
    .rst_n(rst_n),
    .d    (link.sdio),
    .q    (sdi_s)
  );

  // ----------------------------------------
  // Command registers
  // ----------------------------------------
  assign busy  = st_q != H_IDLE;
  assign go    = cmd_wr && cmd_addr == H_CTRL_R && cmd_wdata[H_GO_BIT];
  assign go_rd = cmd_wdata[H_RNW_BIT];
  assign go_ok = sdr_supported(addr_q)
              && !(go_rd && sdr_is_local(addr_q)
                   && !(chsel_q[CH_A_BIT] ^ chsel_q[CH_B_BIT]));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_q  <= 13'h0000;
      wdata_q <= 8'h00;
    end else if (cmd_wr && !busy) begin
      if (cmd_addr == H_ALO_R) begin
        addr_q[7:0] <= cmd_wdata;
      end
      if (cmd_addr == H_AHI_R) begin
        addr_q[12:8] <= cmd_wdata[4:0];
      end
      if (cmd_wr && cmd_addr == H_WD_R) begin
        wdata_q <= cmd_wdata;
      end
    end
  end

  // The host mirrors the channel index it has sent, so that it can refuse
  // a local read that would return an unintended channel.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chsel_q <= CIDX_RST;
      err_q   <= 1'b0;
    end else if (go && !busy) begin
      err_q <= !go_ok;
      if (go_ok && !go_rd && addr_q == CIDX_A) begin
        chsel_q <= wdata_q & CIDX_MASK;
      end
      if (go_ok && !go_rd && addr_q == PCFG_A && |(wdata_q & SOFT_MASK)) begin
        chsel_q <= CIDX_RST;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !cmd_rd) begin
      cmd_rdata <= 8'h00;
    end else begin
      unique case (cmd_addr)
        H_ALO_R:  cmd_rdata <= addr_q[7:0];
        H_AHI_R:  cmd_rdata <= {3'h0, addr_q[12:8]};
        H_WD_R:   cmd_rdata <= wdata_q;
        H_CTRL_R: cmd_rdata <= {6'h00, err_q, busy};
        H_RD_R:   cmd_rdata <= rdata_q;
        default:  cmd_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  assign tick = div_q == HALF_LAST;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q   <= H_IDLE;
      div_q  <= 8'h00;
      bit_q  <= 5'h00;
      fr_q   <= 24'h000000;
      sclk_q <= 1'b0;
      csb_q  <= 1'b1;
      rnw_q  <= 1'b0;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          if (go && go_ok) begin
            fr_q  <= {go_rd, W_SINGLE, addr_q, wdata_q};
            rnw_q <= go_rd;
            csb_q <= 1'b0;
            div_q <= 8'h00;
            bit_q <= 5'h00;
            st_q  <= H_LOW;
          end
        end
        H_LOW: begin
          div_q <= tick ? 8'h00 : div_q + 8'h01;
          if (tick) begin
            sclk_q <= 1'b1;
            st_q   <= H_HIGH;
          end
        end
        H_HIGH: begin
          div_q <= tick ? 8'h00 : div_q + 8'h01;
          if (tick) begin
            sclk_q <= 1'b0;
            if (bit_q == FRAME_LAST) begin
              csb_q <= 1'b1;
              st_q  <= H_IDLE;
            end else begin
              bit_q <= bit_q + 5'h01;
              fr_q  <= {fr_q[22:0], 1'b0};
              st_q  <= (rnw_q && bit_q == INSTR_LAST) ? H_GAP : H_LOW;
            end
          end
        end
        H_GAP: begin
          div_q <= (div_q == GAP_LAST) ? 8'h00 : div_q + 8'h01;
          if (div_q == GAP_LAST) begin
            st_q <= H_LOW;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (st_q == H_LOW && tick && rnw_q && bit_q[4]) begin
      rdata_q <= {rdata_q[6:0], sdi_s};
    end
  end

  assign link.sclk      = sclk_q;
  assign link.csb_n     = csb_q;
  assign link.sdio_h_o  = fr_q[FRAME_BITS-1];
  assign link.sdio_h_oe = !csb_q && !(rnw_q && bit_q[4]);

endmodule
`default_nettype wire

/* File: verif/sdr_checker.sv */
// Concurrent checks on the serial link and the applied settings.
`timescale 1ns/1ps
`default_nettype none
module sdr_checker
  import sdr_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Link
  input wire logic       sclk,
  input wire logic       csb_n,
  input wire logic       sdio_h_o,
  input wire logic       sdio_h_oe,
  input wire logic       sdio_d_oe,
  // Applied settings
  input wire logic [7:0] fmt_a,
  input wire logic [7:0] fmt_b,
  input wire logic       duty_cycle_corrector_en,
  input wire logic       xfer_pulse
);
  // ----------------------------------------
  // Clock edge counter per frame
  // ----------------------------------------
  logic       sclk_q;
  logic [5:0] rise_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge core_clk) begin
    sclk_q <= sclk;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || csb_n) begin
      rise_q <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rise_q <= rise_q + 6'h01;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_XFER_ONE: assert property (xfer_pulse |=> !xfer_pulse)
    else $error("transfer pulse longer than one cycle");
  AST_FMT_A_HELD: assert property ($changed(fmt_a) |->
    $past(xfer_pulse) || fmt_a == FMT_RST)
    else $error("channel A format changed without transfer");
  AST_FMT_B_HELD: assert property ($changed(fmt_b) |->
    $past(xfer_pulse) || fmt_b == FMT_RST)
    else $error("channel B format changed without transfer");
  AST_DCC_HELD: assert property ($changed(duty_cycle_corrector_en) |->
    $past(xfer_pulse) || duty_cycle_corrector_en)
    else $error("duty cycle setting changed without transfer");
  AST_SCLK_IDLE: assert property (csb_n |-> !sclk)
    else $error("serial clock high outside a frame");
  AST_NO_FIGHT: assert property (!(sdio_d_oe && sdio_h_oe))
    else $error("both ends drive the data wire");
  AST_DEV_OE_CS: assert property (sdio_d_oe |-> !csb_n)
    else $error("device drives while deselected");
  AST_HOST_STABLE: assert property (sclk && $past(sclk) |->
    $stable(sdio_h_o))
    else $error("host data moved while clock high");
  AST_FRAME_24: assert property ($rose(csb_n) |-> rise_q == 6'h18)
    else $error("frame did not carry 24 clock edges");
endmodule
`default_nettype wire

/* File: verif/shadowed_dual_channel_regmap_tb_top.sv */
// Self-checking bench joining host end and device end.
`timescale 1ns/1ps
`default_nettype none
module shadowed_dual_channel_regmap_tb_top;
  import sdr_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b1;
  logic [2:0] cmd_addr = 3'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic       cmd_wr = 1'b0;
  logic       cmd_rd = 1'b0;
  logic [7:0] cmd_rdata;
  logic [7:0] fmt_a;
  logic [7:0] fmt_b;
  logic       dcc_en;
  logic [1:0] chan_sel;
  logic       xfer_pulse;
  int         n_fail = 0;
  int         total_checks = 0;
  int         n_xfer = 0;
  int         cyc = 0;

  sdr_spi_if link();

  sdr_host i_sdr_host (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));

  sdr_dev i_sdr_dev (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .fmt_a(fmt_a), .fmt_b(fmt_b), .duty_cycle_corrector_en(dcc_en),
    .chan_sel(chan_sel), .xfer_pulse(xfer_pulse));

  sdr_checker i_sdr_checker (.core_clk(core_clk), .rst_n(rst_n),
    .sclk(link.sclk), .csb_n(link.csb_n), .sdio_h_o(link.sdio_h_o),
    .sdio_h_oe(link.sdio_h_oe), .sdio_d_oe(link.sdio_d_oe),
    .fmt_a(fmt_a), .fmt_b(fmt_b), .duty_cycle_corrector_en(dcc_en),
    .xfer_pulse(xfer_pulse));

  always #2.5 core_clk = ~core_clk;

  // The ceiling is far above the roughly 5k cycles the scenarios need.
  always @(posedge core_clk) begin
    cyc++;
    if (xfer_pulse === 1'b1) begin
      n_xfer++;
    end
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_wr    <= 1'b1;
    @(posedge core_clk);
    cmd_wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    cmd_addr <= a;
    cmd_rd   <= 1'b1;
    @(posedge core_clk);
    cmd_rd   <= 1'b0;
    #1 d = cmd_rdata;
  endtask

  // One serial frame through the command port; waits for busy to drop.
  task automatic xfr(input logic rnw, input logic [12:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    logic [7:0] st;
    int         n;
    bus_wr(H_ALO_R, a[7:0]);
    bus_wr(H_AHI_R, {3'h0, a[12:8]});
    bus_wr(H_WD_R, d);
    bus_wr(H_CTRL_R, rnw ? 8'h03 : 8'h01);
    st = 8'h01;
    for (n = 0; n < 400 && st[H_GO_BIT] !== 1'b0; n++) begin
      bus_rd(H_CTRL_R, st);
    end
    chk(st, 8'h00);
    if (rnw) begin
      bus_rd(H_RD_R, r);
    end
    // Lets the device's crossing settle the written byte.
    repeat (8) @(posedge core_clk);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfr(1'b0, a, d, r);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] r;
    xfr(1'b1, a, 8'h00, r);
    chk(r, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults;
    chk({6'h00, chan_sel}, 8'h03);
    chk(fmt_a, 8'h05);
    chk(fmt_b, 8'h05);
    chk({7'h00, dcc_en}, 8'h01);
    rd_chk(PCFG_A, 8'h18);
    wr(CIDX_A, 8'h01);
    rd_chk(FMT_A, 8'h05);
  endtask

  task automatic t_shadow;
    int x;
    wr(FMT_A, 8'h00);
    chk(fmt_a, 8'h05);
    rd_chk(FMT_A, 8'h00);
    x = n_xfer;
    wr(XFER_A, 8'h00);
    chk(8'(n_xfer - x), 8'h00);
    chk(fmt_a, 8'h05);
    wr(XFER_A, 8'h01);
    chk(8'(n_xfer - x), 8'h01);
    chk(fmt_a, 8'h00);
    chk(fmt_b, 8'h05);
  endtask

  task automatic t_both;
    wr(CIDX_A, 8'h03);
    wr(FMT_A, 8'h07);
    wr(XFER_A, 8'h01);
    chk(fmt_a, 8'h07);
    chk(fmt_b, 8'h07);
    wr(CIDX_A, 8'h02);
    rd_chk(FMT_A, 8'h07);
  endtask

  task automatic t_global;
    wr(CLK_A, 8'h00);
    wr(XFER_A, 8'h01);
    chk({7'h00, dcc_en}, 8'h00);
    wr(CIDX_A, 8'h01);
    rd_chk(CLK_A, 8'h00);
    rd_chk(CIDX_A, 8'h01);
  endtask

  task automatic t_soft;
    wr(PCFG_A, 8'h24);
    rd_chk(PCFG_A, 8'h18);
    chk(fmt_a, 8'h05);
    chk({7'h00, dcc_en}, 8'h01);
    wr(CIDX_A, 8'h02);
    rd_chk(FMT_A, 8'h05);
  endtask

  task automatic t_refuse;
    logic [7:0] st;
    bus_wr(H_ALO_R, 8'h03);
    bus_wr(H_AHI_R, 8'h00);
    bus_wr(H_CTRL_R, 8'h01);
    bus_rd(H_CTRL_R, st);
    chk(st, 8'h02);
    wr(CIDX_A, 8'h03);
    bus_wr(H_ALO_R, FMT_A[7:0]);
    bus_wr(H_CTRL_R, 8'h03);
    bus_rd(H_CTRL_R, st);
    chk(st, 8'h02);
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    // Reset opens with an edge so that the link-side flops see it.
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_defaults();
    t_shadow();
    t_both();
    t_global();
    t_soft();
    t_refuse();
    tally_and_finish();
  end
endmodule
`default_nettype wire
